// ---- rtl/host_bridge_consts.vh ----
// Constants for the host bridge address decoder and config access logic.
// Assumes 36-bit processor addresses and 16-bit I/O addresses.
`ifndef HOST_BRIDGE_CONSTS_VH
`define HOST_BRIDGE_CONSTS_VH
`define HB_DOS_TOP        36'h00007ffff
`define HB_ISA_TOP        36'h00009ffff
`define HB_VGA_TOP        36'h0000bffff
`define HB_EXP_TOP        36'h0000dffff
`define HB_EXT_TOP        36'h0000effff
`define HB_LOW_TOP        36'h0000fffff
`define HB_HOLE_BASE      36'h000f00000
`define HB_HOLE_TOP       36'h000ffffff
`define HB_APIC_BASE      36'h0fec00000
`define HB_APIC_TOP       36'h0fec0ffff
`define HB_MAX_TOM        36'h200000000
`define HB_SMR_TOM        36'h010000000
`define HB_SEG_LSB        14
`define HB_TGT_OFFSET     16'h0cf8
`define HB_DATA_OFFSET    16'h0cfc
`define HB_TGT_RESET      32'h00000000
`define HB_EN_BIT         31
`define HB_BUS_HI         23
`define HB_BUS_LO         16
`define HB_DEV_HI         15
`define HB_DEV_LO         11
`define HB_FN_HI          10
`define HB_FN_LO          8
`define HB_REG_HI         7
`define HB_REG_LO         2
`define HB_IDSEL_LO       11
`define HB_IDSEL_N        21
`define HB_RST_STEP       4'h8
`define HB_RST_CNT_W      4
`endif

// ---- rtl/host_bridge_address_decode_cfg.v ----
// Host bridge: memory decode below 1 MB and in extended memory, config
// mechanism through I/O target-select and data window, and reset ordering.
// Assumes one synchronous host clock; config slave answers in one cycle.
`timescale 1ns/1ns
`include "host_bridge_consts.vh"
module host_bridge_address_decode_cfg (
	// Clock and reset
	input  wire        sys_clk_i,
	input  wire        rst_b_i,
	// Platform reset chain
	input  wire        pci_bus_reset_n_i,
	output reg         processor_reset_n_o,
	output reg         agent_zero_request_n_o,
	// Attribute settings: {read enable, write enable} per block
	input  wire        isa_to_mem_i,
	input  wire [15:0] exp_attr_i,
	input  wire [7:0]  ext_attr_i,
	input  wire [1:0]  sys_attr_i,
	input  wire        hole_en_i,
	input  wire        ext_system_mgmt_ram_en_i,
	input  wire        system_mgmt_ram_open_i,
	input  wire [35:0] top_of_mem_i,
	// Processor memory request
	input  wire        mem_req_i,
	input  wire        mem_write_i,
	input  wire        system_mgmt_mode_i,
	input  wire [35:0] mem_addr_i,
	output reg         route_mem_o,
	output reg         route_pci_o,
	output reg         route_apic_o,
	output reg         uncacheable_o,
	// Inbound PCI memory request
	input  wire        pci_req_i,
	input  wire [35:0] pci_addr_i,
	output reg         pci_snoop_o,
	// Processor I/O port
	input  wire        io_req_i,
	input  wire        io_write_i,
	input  wire [15:0] io_addr_i,
	input  wire [3:0]  io_be_i,
	input  wire [31:0] io_wdata_i,
	output reg  [31:0] io_rdata_o,
	output reg         io_claim_o,
	output reg         io_forward_o,
	// Configuration cycle request to PCI side
	output reg         cfg_req_o,
	output reg         cfg_write_o,
	output reg  [7:0]  cfg_bus_o,
	output reg  [4:0]  cfg_dev_o,
	output reg  [2:0]  cfg_fn_o,
	output reg  [5:0]  cfg_reg_o,
	output reg  [3:0]  cfg_be_o,
	output reg  [31:0] cfg_wdata_o,
	output reg  [20:0] cfg_idsel_o,
	input  wire [31:0] cfg_rdata_i
);

	reg  [31:0]              cfg_target_select;
	reg  [`HB_RST_CNT_W-1:0] rst_cnt;
	reg                      next_route_mem;
	reg                      next_route_apic;
	reg                      next_uncache;
	reg                      next_snoop;
	wire [35:0]              eff_tom;
	wire                     tgt_hit;
	wire                     data_hit;
	wire                     cfg_on;

	// Decode map in priority order, lowest address first:
	//   fixed low area, selectable window, graphics and mgmt RAM area,
	//   attribute blocks up to 1 MB, optional hole, interrupt block,
	//   then main memory up to the effective top.
	// The interrupt block is tested before main memory, so a large
	// installed top never hides it.
	// Each attribute block carries a pair of bits: read to memory and
	// write to memory. Pair 00 sends both to PCI, which is the state out
	// of reset for the system block. Pair 01 is the copy state: reads
	// come from ROM on PCI, writes fill RAM. Pair 10 is the shadowed
	// state: reads from RAM, writes fall through to the ROM side.
	// Pair 11 makes the block plain RAM.
	// The segment index is taken straight from address bits above the
	// 16 KB boundary; this only works because every table base is
	// aligned to its own size.
	// Limitation: callers must range check before using the result,
	// since the function answers for any address it is handed.

	// Attribute pair for the block holding an address; bit 1 reads, bit 0 writes
	function [1:0] blk_attr;
		input [35:0] a;
		begin
			if (a <= `HB_EXP_TOP)
				blk_attr = exp_attr_i[{a[`HB_SEG_LSB+2:`HB_SEG_LSB], 1'b0} +: 2];
			else if (a <= `HB_EXT_TOP)
				blk_attr = ext_attr_i[{a[`HB_SEG_LSB+1:`HB_SEG_LSB], 1'b0} +: 2];
			else
				blk_attr = sys_attr_i;
		end
	endfunction

	// True when an address in C0000h-FFFFFh maps to memory for this access
	function blk_mem;
		input [35:0] a;
		input        wr;
		reg   [1:0]  at;
		begin
			at = blk_attr(a);
			blk_mem = wr ? at[0] : at[1];
		end
	endfunction

	assign eff_tom = ext_system_mgmt_ram_en_i ? `HB_SMR_TOM :
		((top_of_mem_i > `HB_MAX_TOM) ? `HB_MAX_TOM : top_of_mem_i);

	// Processor memory decode; read/write attributes give copy and shadow states
	always @* begin
		next_route_mem  = 1'b0;
		next_route_apic = 1'b0;
		next_uncache    = 1'b0;
		if (mem_addr_i <= `HB_DOS_TOP)
			next_route_mem = 1'b1;
		else if (mem_addr_i <= `HB_ISA_TOP)
			next_route_mem = isa_to_mem_i;
		else if (mem_addr_i <= `HB_VGA_TOP) begin
			next_route_mem = system_mgmt_mode_i | system_mgmt_ram_open_i;
			next_uncache   = 1'b1;
		end
		else if (mem_addr_i <= `HB_LOW_TOP)
			next_route_mem = blk_mem(mem_addr_i, mem_write_i);
		else if (hole_en_i && mem_addr_i >= `HB_HOLE_BASE && mem_addr_i <= `HB_HOLE_TOP)
			next_route_mem = 1'b0;
		else if (mem_addr_i >= `HB_APIC_BASE && mem_addr_i <= `HB_APIC_TOP)
			next_route_apic = 1'b1;
		else
			next_route_mem = (mem_addr_i < eff_tom);
	end

	// Inbound PCI snoop decision
	always @* begin
		next_snoop = 1'b1;
		if (pci_addr_i > `HB_VGA_TOP && pci_addr_i <= `HB_LOW_TOP && blk_attr(pci_addr_i) == 2'b10)
			next_snoop = 1'b0;
		else if (pci_addr_i >= eff_tom)
			next_snoop = 1'b0;
	end

	// Registered routing answer, one cycle after request
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			route_mem_o   <= 1'b0;
			route_pci_o   <= 1'b0;
			route_apic_o  <= 1'b0;
			uncacheable_o <= 1'b0;
			pci_snoop_o   <= 1'b0;
		end else begin
			route_mem_o   <= mem_req_i & next_route_mem;
			route_apic_o  <= mem_req_i & next_route_apic;
			route_pci_o   <= mem_req_i & ~next_route_mem & ~next_route_apic;
			uncacheable_o <= mem_req_i & next_uncache;
			pci_snoop_o   <= pci_req_i & next_snoop;
		end
	end

	assign tgt_hit  = io_req_i && io_addr_i == `HB_TGT_OFFSET && io_be_i == 4'hf;
	assign cfg_on   = cfg_target_select[`HB_EN_BIT];
	assign data_hit = io_req_i && io_addr_i == `HB_DATA_OFFSET && cfg_on;

	// Config access flow, one request per cycle:
	//   a full dword write to the select port loads the target register;
	//   a data port access with the enable bit set launches a config
	//   cycle with the fields frozen from the select register.
	// Fields stay on the outputs until the next data port access, so the
	// far side may take them late without a hold register of its own.
	// Read data is captured from the far side in the request cycle; the
	// far side must answer combinationally, which keeps this path short
	// but pushes the timing burden onto the target.
	// A narrow select port access never touches the register and is
	// passed on, which keeps byte-wide legacy ports at that address alive.

	// Target-select register and config cycle launch; single-cycle answer
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_target_select <= `HB_TGT_RESET;
			io_rdata_o        <= 32'h00000000;
			io_claim_o        <= 1'b0;
			io_forward_o      <= 1'b0;
			cfg_req_o         <= 1'b0;
			cfg_write_o       <= 1'b0;
			cfg_bus_o         <= 8'h00;
			cfg_dev_o         <= 5'h00;
			cfg_fn_o          <= 3'h0;
			cfg_reg_o         <= 6'h00;
			cfg_be_o          <= 4'h0;
			cfg_wdata_o       <= 32'h00000000;
			cfg_idsel_o       <= 21'h000000;
		end else begin
			io_claim_o   <= tgt_hit | data_hit;
			io_forward_o <= io_req_i & ~tgt_hit & ~data_hit;
			cfg_req_o    <= data_hit;
			if (tgt_hit && io_write_i)
				cfg_target_select <= io_wdata_i;
			if (tgt_hit && !io_write_i)
				io_rdata_o <= cfg_target_select;
			else if (data_hit && !io_write_i)
				io_rdata_o <= cfg_rdata_i;
			if (data_hit) begin
				cfg_write_o <= io_write_i;
				cfg_bus_o   <= cfg_target_select[`HB_BUS_HI:`HB_BUS_LO];
				cfg_dev_o   <= cfg_target_select[`HB_DEV_HI:`HB_DEV_LO];
				cfg_fn_o    <= cfg_target_select[`HB_FN_HI:`HB_FN_LO];
				cfg_reg_o   <= cfg_target_select[`HB_REG_HI:`HB_REG_LO];
				cfg_be_o    <= io_be_i;
				cfg_wdata_o <= io_wdata_i;
				// one-hot IDSEL for devices below 21 on bus 0 only; all others get all-zero IDSEL
				cfg_idsel_o <= (cfg_target_select[`HB_BUS_HI:`HB_BUS_LO] == 8'h00 &&
					cfg_target_select[`HB_DEV_HI:`HB_DEV_LO] < `HB_IDSEL_N) ?
					(21'h000001 << cfg_target_select[`HB_DEV_HI:`HB_DEV_LO]) : 21'h000000;
			end
		end
	end

	// Reset chain: while the PCI reset input is low the processor is held
	// in reset and the agent-zero request is driven. Once it rises, a
	// short counter keeps the request standing for a fixed number of
	// cycles so that every processor latches its agent identity before
	// it leaves reset. Release of reset and of the request share one
	// edge, so reset is held with the request gone only from the bridge reset to the first clock after it.
	// A new PCI reset pulse restarts the whole sequence from the top.

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_cnt                <= {`HB_RST_CNT_W{1'b0}};
			processor_reset_n_o    <= 1'b0;
			agent_zero_request_n_o <= 1'b1;
		end else if (!pci_bus_reset_n_i) begin
			rst_cnt                <= {`HB_RST_CNT_W{1'b0}};
			processor_reset_n_o    <= 1'b0;
			agent_zero_request_n_o <= 1'b0;
		end else if (rst_cnt != `HB_RST_STEP) begin
			rst_cnt                <= rst_cnt + 1'b1;
			agent_zero_request_n_o <= 1'b0;
		end else begin
			processor_reset_n_o    <= 1'b1;
			agent_zero_request_n_o <= 1'b1;
		end
	end

endmodule // host_bridge_address_decode_cfg

// ---- test/hb_decode_sva.sv ----
// Checker for the host bridge: routing, config select, reset ordering.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module hb_decode_sva (
	// Clock, reset and reset chain
	input wire logic        sys_clk_i, rst_b_i, pci_bus_reset_n_i,
	input wire logic        processor_reset_n_o, agent_zero_request_n_o,
	// Memory side
	input wire logic        mem_req_i, system_mgmt_mode_i, hole_en_i, pci_req_i, pci_snoop_o,
	input wire logic [1:0]  sys_attr_i,
	input wire logic [35:0] mem_addr_i, pci_addr_i,
	input wire logic        route_mem_o, route_pci_o, route_apic_o, uncacheable_o,
	// I/O and config side
	input wire logic        io_req_i, io_claim_o, io_forward_o, cfg_req_o,
	input wire logic [15:0] io_addr_i,
	input wire logic [3:0]  io_be_i,
	input wire logic [7:0]  cfg_bus_o,
	input wire logic [4:0]  cfg_dev_o,
	input wire logic [20:0] cfg_idsel_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	AST_DOS: assert property (mem_req_i && mem_addr_i < 36'h80000 |=> route_mem_o)
		else $error("low area not routed to memory");
	AST_ONE: assert property (mem_req_i |=> $onehot({route_mem_o, route_pci_o, route_apic_o}))
		else $error("route not unique");
	AST_APIC: assert property (mem_req_i && mem_addr_i[35:16] == 20'h0fec0 |=> route_apic_o)
		else $error("interrupt block missed");
	AST_HOLE: assert property (mem_req_i && hole_en_i && mem_addr_i[35:20] == 16'h00f |=> route_pci_o)
		else $error("hole not on PCI");
	AST_SMM: assert property (mem_req_i && system_mgmt_mode_i && mem_addr_i[35:17] == 19'h5
		|=> route_mem_o && uncacheable_o)
		else $error("mgmt RAM routing wrong");
	AST_SNOOP: assert property (pci_req_i && pci_addr_i[35:16] == 20'h0000f && sys_attr_i == 2'b10
		|=> !pci_snoop_o)
		else $error("shadowed hit forwarded");
	AST_NARROW: assert property (io_req_i && io_addr_i == 16'h0cf8 && io_be_i != 4'hf
		|=> io_forward_o && !io_claim_o)
		else $error("narrow select access claimed");
	AST_CAUSE: assert property (cfg_req_o |-> $past(io_req_i && io_addr_i == 16'h0cfc))
		else $error("config cycle without data access");
	AST_IDSEL: assert property (cfg_req_o && cfg_bus_o == 8'h00 && cfg_dev_o < 5'd21
		|-> cfg_idsel_o == 21'h1 << cfg_dev_o)
		else $error("select line wrong");
	AST_CHAIN: assert property (!pci_bus_reset_n_i |=> !processor_reset_n_o && !agent_zero_request_n_o)
		else $error("processor not held in reset");
	AST_WAIT: assert property ($rose(pci_bus_reset_n_i) |=> !processor_reset_n_o [*6])
		else $error("processor released early");
	AST_ORDER: assert property ($rose(processor_reset_n_o) |-> !$past(agent_zero_request_n_o))
		else $error("request not held before release");
	cover property (cfg_req_o);
	cover property (io_forward_o);
	cover property (route_apic_o);
endmodule // hb_decode_sva

// ---- test/hb_cfg_target.sv ----
// Config target model: one dword of storage answering every config cycle.
// Assumes config requests arrive as one-cycle pulses from the bridge.
`timescale 1ns/1ns
module hb_cfg_target (
	input  wire logic        sys_clk_i,
	input  wire logic        cfg_req_o,
	input  wire logic        cfg_write_o,
	input  wire logic [3:0]  cfg_be_o,
	input  wire logic [31:0] cfg_wdata_o,
	output logic      [31:0] cfg_rdata_i = 32'h00000000
);
	always @(posedge sys_clk_i)
		if (cfg_req_o && cfg_write_o)
			for (int j = 0; j < 4; j++)
				if (cfg_be_o[j]) cfg_rdata_i[8*j+:8] <= cfg_wdata_o[8*j+:8];
endmodule // hb_cfg_target

// ---- test/test_host_bridge_address_decode_cfg.sv ----
// Testbench for the host bridge: memory routing, config access, reset chain.
// Assumes the config target model returns its stored dword on reads.
`timescale 1ns/1ns
module test_host_bridge_address_decode_cfg;
	logic        sys_clk_i = 0, rst_b_i = 0, pci_bus_reset_n_i = 0, isa_to_mem_i = 0;
	logic        hole_en_i = 0, ext_system_mgmt_ram_en_i = 0, system_mgmt_ram_open_i = 0, mem_req_i = 0;
	logic        mem_write_i = 0, system_mgmt_mode_i = 0, pci_req_i = 0, io_req_i = 0;
	logic        io_write_i = 0;
	logic [15:0] exp_attr_i = 0, io_addr_i = 0;
	logic [7:0]  ext_attr_i = 0;
	logic [1:0]  sys_attr_i = 0;
	logic [35:0] top_of_mem_i = 36'h200000000, mem_addr_i = 0, pci_addr_i = 0;
	logic [3:0]  io_be_i = 0, b;
	logic [31:0] io_wdata_i = 0, io_rdata_o, cfg_wdata_o, d, mirror = 0;
	logic [34:0] en;
	wire         processor_reset_n_o, agent_zero_request_n_o, route_mem_o, route_pci_o;
	wire         route_apic_o, uncacheable_o, pci_snoop_o, io_claim_o, io_forward_o;
	wire         cfg_req_o, cfg_write_o;
	wire [7:0]   cfg_bus_o;
	wire [4:0]   cfg_dev_o;
	wire [2:0]   cfg_fn_o;
	wire [5:0]   cfg_reg_o;
	wire [3:0]   cfg_be_o;
	wire [20:0]  cfg_idsel_o;
	wire [31:0]  cfg_rdata_i;
	int          failures = 0, comparisons = 0;
	logic [2:0]  qm[$];
	logic [34:0] qi[$];
	logic [26:0] qc[$], ec;
	always #10 sys_clk_i = ~sys_clk_i;
	host_bridge_address_decode_cfg i_host_bridge_address_decode_cfg (.*);
	hb_cfg_target i_hb_cfg_target (.*);
	task automatic stop_test;
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [34:0] e, input logic [34:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Route code is {interrupt block, PCI, memory}; PCI request mirrors the address
	task automatic mem(input logic [35:0] a, input logic w, input logic [2:0] e);
		@(negedge sys_clk_i);
		qm.push_back(e);
		{mem_req_i, mem_write_i, mem_addr_i, pci_req_i, pci_addr_i} = {1'b1, w, a, 1'b1, a};
		@(negedge sys_clk_i);
		{mem_req_i, pci_req_i} = 2'b00;
	endtask
	// Note is {read, claim, forward, read data}
	task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
		input logic [31:0] dt, input logic [34:0] e);
		@(negedge sys_clk_i);
		qi.push_back(e);
		{io_req_i, io_write_i, io_addr_i, io_be_i, io_wdata_i} = {1'b1, w, a, be, dt};
		@(negedge sys_clk_i);
		io_req_i = 0;
	endtask
	// Outputs are pulses, so they are taken at the falling edge when settled
	always @(negedge sys_clk_i) begin
		if (route_mem_o | route_pci_o | route_apic_o)
			chk("route", qm.pop_front(), {route_apic_o, route_pci_o, route_mem_o});
		if (io_claim_o | io_forward_o) begin
			en = qi.pop_front();
			chk("io", en, {en[34], io_claim_o, io_forward_o, en[34] ? io_rdata_o : en[31:0]});
		end
		// Config cycle fields and select line
		if (cfg_req_o) begin
			ec = qc.pop_front();
			chk("cfg", ec, {cfg_write_o, cfg_bus_o, cfg_dev_o, cfg_fn_o, cfg_reg_o, cfg_be_o});
			chk("idsel", 35'h20, cfg_idsel_o);
		end
	end
	// Limit well above the roughly 120 cycles the sequence needs
	initial begin
		#50000;
		failures++;
		stop_test;
	end
	initial begin
		void'($urandom(24));
		exp_attr_i = $urandom;
		ext_attr_i = $urandom;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i) rst_b_i = 1;
		repeat (3) @(negedge sys_clk_i);
		pci_bus_reset_n_i = 1;
		repeat (7) @(negedge sys_clk_i);
		chk("cpu_reset", 0, {processor_reset_n_o, agent_zero_request_n_o});
		repeat (3) @(negedge sys_clk_i);
		chk("cpu_reset", 3, {processor_reset_n_o, agent_zero_request_n_o});
		mem(36'h0, 0, 1);
		mem(36'h7ffff, 1, 1);
		mem(36'h9ffff, 0, 2);
		isa_to_mem_i = 1;
		mem(36'h80000, 0, 1);
		mem(36'ha0000, 0, 2);
		system_mgmt_mode_i = 1;
		mem(36'hbffff, 0, 1);
		system_mgmt_mode_i = 0;
		for (int k = 0; k < 8; k++) begin
			mem(36'hc0000 + 36'(k) * 16384, 0, exp_attr_i[2*k+1] ? 3'd1 : 3'd2);
			mem(36'hc3fff + 36'(k) * 16384, 1, exp_attr_i[2*k] ? 3'd1 : 3'd2);
		end
		for (int k = 0; k < 4; k++)
			mem(36'he0000 + 36'(k) * 16384, 0, ext_attr_i[2*k+1] ? 3'd1 : 3'd2);
		mem(36'hf8000, 0, 2);
		sys_attr_i = 2'b01;
		mem(36'hf0000, 0, 2);
		mem(36'hf0000, 1, 1);
		sys_attr_i = 2'b10;
		mem(36'hfffff, 0, 1);
		mem(36'hfffff, 1, 2);
		mem(36'hf00000, 0, 1);
		hole_en_i = 1;
		mem(36'hf00000, 0, 2);
		mem(36'hffffff, 1, 2);
		mem(36'h1ffffffff, 0, 1);
		mem(36'h200000000, 0, 2);
		ext_system_mgmt_ram_en_i = 1;
		mem(36'hfffffff, 0, 1);
		mem(36'h10000000, 0, 2);
		mem(36'hfec0ffff, 0, 4);
		io(1, 16'h0cf8, 4'hf, 32'h8000280c, 35'h200000000);
		for (int k = 0; k < 3; k++) begin
			b = $urandom;
			d = $urandom;
			qc.push_back({1'b1, 8'h00, 5'h05, 3'h0, 6'h03, b});
			io(1, 16'h0cfc, b, d, 35'h200000000);
			for (int j = 0; j < 4; j++)
				if (b[j]) mirror[8*j+:8] = d[8*j+:8];
			qc.push_back({1'b0, 8'h00, 5'h05, 3'h0, 6'h03, 4'hf});
			io(0, 16'h0cfc, 4'hf, 0, {3'b110, mirror});
		end
		io(1, 16'h0cf8, 4'h3, 0, 35'h100000000);
		io(0, 16'h0cf8, 4'hf, 0, {3'b110, 32'h8000280c});
		io(1, 16'h0cf8, 4'hf, 32'h0000280c, 35'h200000000);
		io(0, 16'h0cfc, 4'hf, 0, 35'h100000000);
		repeat (3) @(negedge sys_clk_i);
		// A result that never appeared counts as a mismatch
		if (qm.size() + qi.size() + qc.size() != 0)
			failures++;
		stop_test;
	end
endmodule // test_host_bridge_address_decode_cfg
bind host_bridge_address_decode_cfg hb_decode_sva i_hb_decode_sva (.*);
